/* File: rtl/xdbp_pkg.sv */
/*
 Package for the external data bus port block: phase encodings, timing counts, reset values.
 Assumes a single 200 MHz core clock.
*/
package xdbp_pkg;
  localparam int XDBP_CLK_MHZ = 200;
  localparam int XDBP_PHASE_NS = 20;
  localparam int XDBP_PHASE_CYC = (XDBP_PHASE_NS * XDBP_CLK_MHZ + 999) / 1000;
  localparam int XDBP_STRAP_NS = 50;
  localparam int XDBP_STRAP_CYC = (XDBP_STRAP_NS * XDBP_CLK_MHZ + 999) / 1000;
  localparam int XDBP_ADDR_W = 24;
  localparam int XDBP_BYTE_W = 8;
  localparam logic [7:0] XDBP_PORT_RST = 8'hff;
  localparam int XDBP_LOW_LSB = 0;
  localparam int XDBP_MID_LSB = 8;
  localparam int XDBP_PAGE_LSB = 16;
  typedef enum logic [2:0] {
    XDBP_IDLE = 3'b000,
    XDBP_ALE = 3'b001,
    XDBP_HOLD = 3'b011,
    XDBP_DATA = 3'b010,
    XDBP_END = 3'b110
  } xdbp_state_t;
endpackage

/* File: rtl/xdbp_strap.sv */
/*
 Program store strobe pin handler: samples the strap after reset, then drives the pin low.
 Assumes rst_n is already synchronous-released by the system.
*/
`timescale 1ns/1ps
module xdbp_strap import xdbp_pkg::*; #(
  parameter int STRAP_CYC = XDBP_STRAP_CYC
) (
  input wire logic sys_clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic pss_in, // Strobe pin level
  output logic pss_out, // Strobe pin drive value
  output logic pss_oe, // Strobe pin drive enable
  output logic download_r, // Serial download kernel selected
  output logic strap_done_r // Sampling finished, core may run
);
  logic [15:0] cnt_r, cnt_nxt;
  logic done_nxt, dl_nxt, oe_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = strap_done_r;
    dl_nxt = download_r;
    oe_nxt = pss_oe;
    if (!strap_done_r) begin
      if (cnt_r == 16'(STRAP_CYC - 1)) begin
        done_nxt = 1'b1;
        dl_nxt = !pss_in;
        oe_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      strap_done_r <= 1'b0;
      download_r <= 1'b0;
      pss_oe <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      strap_done_r <= done_nxt;
      download_r <= dl_nxt;
      pss_oe <= oe_nxt;
    end
  end

  assign pss_out = 1'b0;

  a_strobe_low_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
    strap_done_r |-> pss_oe && !pss_out) else $error("strobe not driven low while running");
  a_strap_input: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !strap_done_r |-> !pss_oe) else $error("strobe driven during sampling");
  a_strap_sample: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(strap_done_r) |-> download_r == !$past(pss_in)) else $error("wrong boot choice");
endmodule

/* File: rtl/xdbp_top.sv */
/*
 External data bus port pins: multiplexed low/high address-data ports, latch strobe, boot strap.
 Assumes the core issues one access request at a time and holds its fields while busy.
*/
// Behaviour
// - During external access high-bus port drives address bits 8 to 15.
// - High-bus port also drives page byte bits 16 to 23, multiplexed.
// - Low-bus port carries address bits 0 to 7, then the data byte.
// - Low-bus port drives ones actively while acting as external bus.
// - General-purpose low-bus port is open-drain; written ones release the pin.
// - General-purpose high-bus port ones are only weakly held high.
// - Latch strobe pulses to capture low byte and page byte each access.
// - External code select held high; code fetched only internally.
// - Program store strobe stays low during internal execution.
// - At reset the strobe pin becomes input and is sampled.
// - Sampled low selects download kernel, otherwise user code runs.
`timescale 1ns/1ps
module xdbp_top import xdbp_pkg::*; #(
  parameter int PHASE_CYC = XDBP_PHASE_CYC,
  parameter int STRAP_CYC = XDBP_STRAP_CYC
) (
  input wire logic sys_clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] lowbus_latch, // Low-bus general-purpose latch
  input wire logic [7:0] highbus_latch, // High-bus general-purpose latch
  input wire logic acc_req, // Start external data access
  input wire logic acc_write, // 1 write, 0 read
  input wire logic [23:0] acc_addr, // Access address
  input wire logic [7:0] acc_wdata, // Write data
  output logic acc_busy, // Access in progress
  output logic acc_done, // One-cycle end-of-access pulse
  output logic [7:0] acc_rdata, // Read data captured
  input wire logic [7:0] lowbus_port_in, // Low-bus pin levels
  output logic [7:0] lowbus_port_out, // Low-bus drive values
  output logic [7:0] lowbus_port_oe, // Low-bus drive enables
  input wire logic [7:0] highbus_port_in, // High-bus pin levels
  output logic [7:0] highbus_port_out, // High-bus drive values
  output logic [7:0] highbus_port_oe, // High-bus strong drive enables
  output logic [7:0] highbus_port_pullup, // High-bus weak pull-up enables
  output logic addr_latch_strobe, // Address latch strobe
  input wire logic ext_code_sel, // External code select level
  output logic internal_fetch, // Internal code fetch allowed
  input wire logic pss_in, // Program store strobe pin level
  output logic pss_out, // Program store strobe drive value
  output logic pss_oe, // Program store strobe enable
  output logic download_mode, // Serial download kernel selected
  output logic core_run // Core may start execution
);
  xdbp_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0] lo_out_nxt, lo_oe_nxt, hi_out_nxt, hi_oe_nxt, hi_pu_nxt, rdata_nxt;
  logic ale_nxt, busy_nxt, done_nxt, fetch_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wr_r, wr_nxt;
  logic strap_done, dl_mode;
  logic pss_out_w, pss_oe_w;

  function automatic logic [7:0] addr_byte(input logic [23:0] a, input int lsb);
    addr_byte = a[lsb +: 8];
  endfunction

  xdbp_strap #(.STRAP_CYC(STRAP_CYC)) u_strap (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pss_in(pss_in),
    .pss_out(pss_out_w),
    .pss_oe(pss_oe_w),
    .download_r(dl_mode),
    .strap_done_r(strap_done)
  );

  wire phase_end = (cnt_r == 16'(PHASE_CYC - 1));

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = phase_end ? 16'h0000 : cnt_r + 16'h0001;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    wr_nxt = wr_r;
    rdata_nxt = acc_rdata;
    done_nxt = 1'b0;
    busy_nxt = 1'b1;
    ale_nxt = 1'b0;
    lo_out_nxt = 8'h00;
    lo_oe_nxt = ~lowbus_latch;
    hi_out_nxt = highbus_latch;
    hi_oe_nxt = ~highbus_latch;
    hi_pu_nxt = highbus_latch;
    fetch_nxt = ext_code_sel && strap_done;
    unique case (st_r)
      XDBP_IDLE: begin
        busy_nxt = 1'b0;
        cnt_nxt = 16'h0000;
        if (acc_req && strap_done) begin
          st_nxt = XDBP_ALE;
          addr_nxt = acc_addr;
          wdata_nxt = acc_wdata;
          wr_nxt = acc_write;
          busy_nxt = 1'b1;
        end
      end
      XDBP_ALE: begin
        ale_nxt = !phase_end;
        if (phase_end)
          st_nxt = XDBP_HOLD;
      end
      XDBP_HOLD: begin
        if (phase_end)
          st_nxt = XDBP_DATA;
      end
      XDBP_DATA: begin
        if (phase_end) begin
          st_nxt = XDBP_END;
          if (!wr_r)
            rdata_nxt = lowbus_port_in;
        end
      end
      XDBP_END: begin
        st_nxt = XDBP_IDLE;
        done_nxt = 1'b1;
        busy_nxt = 1'b0;
      end
    endcase
    if (st_nxt == XDBP_ALE || (st_nxt == XDBP_HOLD && st_r == XDBP_ALE)) begin
      lo_out_nxt = addr_byte(addr_nxt, XDBP_LOW_LSB);
      lo_oe_nxt = 8'hff;
      hi_out_nxt = addr_byte(addr_nxt, XDBP_PAGE_LSB);
      hi_oe_nxt = 8'hff;
      hi_pu_nxt = 8'h00;
    end else if (st_nxt == XDBP_HOLD || st_nxt == XDBP_DATA) begin
      lo_out_nxt = wdata_nxt;
      lo_oe_nxt = wr_nxt ? 8'hff : 8'h00;
      hi_out_nxt = addr_byte(addr_nxt, XDBP_MID_LSB);
      hi_oe_nxt = 8'hff;
      hi_pu_nxt = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= XDBP_IDLE;
      cnt_r <= 16'h0000;
      addr_r <= 24'h000000;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      acc_rdata <= 8'h00;
      acc_done <= 1'b0;
      acc_busy <= 1'b0;
      addr_latch_strobe <= 1'b0;
      lowbus_port_out <= 8'h00;
      lowbus_port_oe <= 8'h00;
      highbus_port_out <= XDBP_PORT_RST;
      highbus_port_oe <= 8'h00;
      highbus_port_pullup <= XDBP_PORT_RST;
      internal_fetch <= 1'b0;
      pss_out <= 1'b0;
      pss_oe <= 1'b0;
      download_mode <= 1'b0;
      core_run <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      wr_r <= wr_nxt;
      acc_rdata <= rdata_nxt;
      acc_done <= done_nxt;
      acc_busy <= busy_nxt;
      addr_latch_strobe <= ale_nxt;
      lowbus_port_out <= lo_out_nxt;
      lowbus_port_oe <= lo_oe_nxt;
      highbus_port_out <= hi_out_nxt;
      highbus_port_oe <= hi_oe_nxt;
      highbus_port_pullup <= hi_pu_nxt;
      internal_fetch <= fetch_nxt;
      pss_out <= pss_out_w;
      pss_oe <= pss_oe_w;
      download_mode <= dl_mode;
      core_run <= strap_done;
    end
  end

  a_page_during_ale: assert property (@(posedge sys_clk) disable iff (!rst_n)
    addr_latch_strobe |-> highbus_port_out == addr_r[23:16] && highbus_port_oe == 8'hff)
    else $error("page byte missing under strobe");
  a_low_during_ale: assert property (@(posedge sys_clk) disable iff (!rst_n)
    addr_latch_strobe |-> lowbus_port_out == addr_r[7:0]) else $error("low byte missing under strobe");
  a_mid_after_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(addr_latch_strobe) ##1 1'b1 |-> highbus_port_out == addr_r[15:8])
    else $error("middle byte not shown after strobe");
  a_low_strong_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    addr_latch_strobe |-> lowbus_port_oe == 8'hff) else $error("low bus not actively driven");
  a_gp_open_drain: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !acc_busy && !$past(acc_busy) && $past(rst_n) && $stable(lowbus_latch) |-> lowbus_port_oe == ~lowbus_latch)
    else $error("open-drain release wrong");
  a_gp_weak_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !acc_busy && !$past(acc_busy) && $past(rst_n) && $stable(highbus_latch) |-> highbus_port_pullup == highbus_latch)
    else $error("weak pull-up wrong");
  a_strobe_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(acc_busy) |=> addr_latch_strobe) else $error("no latch strobe at access start");
  a_fetch_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    internal_fetch |-> $past(ext_code_sel)) else $error("fetch without select high");
  a_done_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc_done |-> !acc_busy && !addr_latch_strobe) else $error("busy after done");
endmodule

/* File: test/xdbp_ext_mem.sv */
/*
 Far-side model: external data memory behind address latches on the multiplexed bus.
 Assumes pin levels are resolved here from the block's drive enables.
*/
`timescale 1ns/1ps
module xdbp_ext_mem #(
  parameter int PHASE_CYC = 4
) (
  input wire logic sys_clk, // Core clock
  input wire logic strap_low, // Pull-down fitted on strobe pin
  input wire logic strobe, // Address latch strobe
  input wire logic [7:0] lo_out, // Low-bus drive values
  input wire logic [7:0] lo_oe, // Low-bus drive enables
  input wire logic [7:0] hi_out, // High-bus drive values
  input wire logic [7:0] hi_oe, // High-bus drive enables
  input wire logic [7:0] hi_pu, // High-bus weak pull-ups
  input wire logic pss_out, // Strobe pin drive value
  input wire logic pss_oe, // Strobe pin drive enable
  output logic [7:0] lo_pin, // Low-bus pin levels
  output logic [7:0] hi_pin, // High-bus pin levels
  output logic pss_pin, // Strobe pin level
  output logic [7:0] lat_low, // Latched low address byte
  output logic [7:0] lat_page, // Latched page byte
  output logic [7:0] mid_seen, // Middle byte seen after latching
  output logic [7:0] wdat_seen // Data seen on low bus
);
  logic [7:0] pat = 8'h00;
  logic strobe_q = 1'b0;
  int acnt = 0;
  logic rd_drive;
  // Undriven pins show a changing pattern, never the last value
  // Byte phases are counted from the strobe fall; memory answers only inside them
  assign rd_drive = acnt != 0 && lo_oe == 8'h00;
  assign hi_pin = (hi_oe & hi_out) | (~hi_oe & hi_pu) | (~hi_oe & ~hi_pu & pat);
  assign lo_pin = (lo_oe & lo_out) | (~lo_oe & (rd_drive ? (lat_low ^ lat_page ^ hi_pin ^ 8'h5a) : pat));
  assign pss_pin = pss_oe ? pss_out : !strap_low;
  always @(posedge sys_clk) begin
    pat <= pat + 8'h37;
    strobe_q <= strobe;
    if (strobe) begin
      lat_low <= lo_pin;
      lat_page <= hi_pin;
    end
    if (strobe_q && !strobe) begin
      acnt <= 1;
    end else if (acnt == 2 * PHASE_CYC - 1) begin
      acnt <= 0;
    end else if (acnt != 0) begin
      acnt <= acnt + 1;
    end
    if (acnt != 0) begin
      mid_seen <= hi_pin;
      if (lo_oe == 8'hff) wdat_seen <= lo_pin;
    end
  end
endmodule

/* File: test/tb_top.sv */
/*
 Self-checking bench for the external data bus port block.
 Assumes the far-side memory model and a 200 MHz core clock.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb_top import xdbp_pkg::*;;
  localparam int P = 4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] lo_latch, hi_latch, acc_wdata, acc_rdata, lo_in, lo_out, lo_oe, hi_in, hi_out, hi_oe, hi_pu;
  logic [7:0] lat_low, lat_page, mid_seen, wdat_seen;
  logic [23:0] acc_addr;
  logic acc_req, acc_write, acc_busy, acc_done, strobe, ext_sel, ifetch, pss_in, pss_out, pss_oe;
  logic dl_mode, core_run, strap_low;
  logic [31:0] r;
  int err_total = 0;
  int checks_done = 0;
  int seed = 58;
  int n;
  always #2.5 sys_clk = ~sys_clk;
  xdbp_top #(.PHASE_CYC(P), .STRAP_CYC(2)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .lowbus_latch(lo_latch),
    .highbus_latch(hi_latch), .acc_req(acc_req), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_busy(acc_busy), .acc_done(acc_done), .acc_rdata(acc_rdata),
    .lowbus_port_in(lo_in), .lowbus_port_out(lo_out), .lowbus_port_oe(lo_oe), .highbus_port_in(hi_in),
    .highbus_port_out(hi_out), .highbus_port_oe(hi_oe), .highbus_port_pullup(hi_pu),
    .addr_latch_strobe(strobe), .ext_code_sel(ext_sel), .internal_fetch(ifetch), .pss_in(pss_in),
    .pss_out(pss_out), .pss_oe(pss_oe), .download_mode(dl_mode), .core_run(core_run));
  xdbp_ext_mem #(.PHASE_CYC(P)) pm (.sys_clk(sys_clk), .strap_low(strap_low), .strobe(strobe), .lo_out(lo_out),
    .lo_oe(lo_oe), .hi_out(hi_out), .hi_oe(hi_oe), .hi_pu(hi_pu), .pss_out(pss_out), .pss_oe(pss_oe),
    .lo_pin(lo_in), .hi_pin(hi_in), .pss_pin(pss_in), .lat_low(lat_low), .lat_page(lat_page),
    .mid_seen(mid_seen), .wdat_seen(wdat_seen));
  task give_verdict;
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk_idle;
    `CHK(acc_busy, 1'b0)
    `CHK(lo_out, 8'h00)
    `CHK(lo_oe, ~lo_latch)
    `CHK(hi_oe, ~hi_latch)
    `CHK(hi_pu, hi_latch)
    `CHK(hi_out & hi_oe, 8'h00)
  endtask
  task do_reset(input logic low, input int cyc);
    rst_n = 1'b0;
    strap_low = low;
    repeat (cyc) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(posedge sys_clk) #1 `CHK(pss_oe, 1'b0)
    n = 0;
    while (!core_run && n < 50) begin
      @(posedge sys_clk) #1 n++;
    end
    `CHK(core_run, 1'b1)
    `CHK(dl_mode, low)
    `CHK(pss_oe, 1'b1)
    `CHK(pss_out, 1'b0)
  endtask
  task access(input logic wr, input logic [23:0] a, input logic [7:0] d);
    acc_req = 1'b1;
    acc_write = wr;
    acc_addr = a;
    acc_wdata = d;
    @(posedge sys_clk) #1 acc_req = 1'b0;
    n = 0;
    while (!strobe && n < 2) begin
      @(posedge sys_clk) #1 n++;
    end
    `CHK(strobe, 1'b1)
    `CHK(hi_out, a[23:16])
    `CHK(lo_out, a[7:0])
    `CHK(lo_oe, 8'hff)
    while (!acc_done && n < 40) begin
      @(posedge sys_clk) #1 n++;
    end
    `CHK(n, 3 * P + 1)
    `CHK(lat_low, a[7:0])
    `CHK(lat_page, a[23:16])
    `CHK(mid_seen, a[15:8])
    if (wr) `CHK(wdat_seen, d)
    else `CHK(acc_rdata, a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a)
  endtask
  initial begin
    lo_latch = 8'ha5;
    hi_latch = 8'h3c;
    acc_req = 1'b0;
    acc_write = 1'b0;
    acc_addr = 24'h000000;
    acc_wdata = 8'h00;
    ext_sel = 1'b1;
    do_reset(1'b0, 3);
    chk_idle;
    ext_sel = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 `CHK(ifetch, 1'b0)
    ext_sel = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK(ifetch, 1'b1)
    access(1'b1, 24'hffffff, 8'hff);
    access(1'b0, 24'h000000, 8'h00);
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      lo_latch = r[7:0];
      hi_latch = r[15:8];
      r = $random(seed);
      access(r[31], r[23:0], r[31:24]);
    end
    @(posedge sys_clk) #1 chk_idle;
    do_reset(1'b1, 24);
    access(1'b0, 24'h123456, 8'h00);
    give_verdict;
  end
  initial begin
    #20000;
    err_total++;
    give_verdict;
  end
endmodule
